// ---- shared/gport_pkg.sv ----
// Package of constants and carrier types for the grant status arbiter
package gport_pkg;

  // Grant status codes driven on the status lines
  localparam logic [2:0] ST_LP_READ    = 3'h0;
  localparam logic [2:0] ST_HP_READ    = 3'h1;
  localparam logic [2:0] ST_LP_WRITE   = 3'h2;
  localparam logic [2:0] ST_HP_WRITE   = 3'h3;
  localparam logic [2:0] ST_START_XACT = 3'h7;

  // Reset value of the status lines (idle grant code)
  localparam logic [2:0] ST_RESET = ST_START_XACT;

  // Port clock edge detection: sampled levels
  localparam logic [1:0] EDGE_RISE = 2'h1;

  // Widths
  localparam int SBA_WIDTH = 8;
  localparam int TAG_WIDTH = 4;

  // Kinds of pending work the core logic may schedule
  typedef enum logic [2:0] {
    WORK_LP_READ  = 3'b000,
    WORK_HP_READ  = 3'b001,
    WORK_LP_WRITE = 3'b010,
    WORK_HP_WRITE = 3'b011,
    WORK_START    = 3'b111
  } work_kind_type;

  // One scheduled grant: kind and a tag naming the transaction
  typedef struct packed {
    work_kind_type        kind;
    logic [TAG_WIDTH-1:0] tag;
  } grant_word_type;

  // One captured request from the master
  typedef struct packed {
    logic                 from_sideband;
    logic [SBA_WIDTH-1:0] sideband_byte;
  } request_word_type;

endpackage

// ---- rtl/grant_buffer.sv ----
// Two-entry valid/ready buffer for issued grant words
`timescale 1ns/1ps
module grant_buffer
  import gport_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           in_valid,
  output logic                in_ready,
  input  wire grant_word_type in_data,
  output logic                out_valid,
  input  wire logic           out_ready,
  output grant_word_type      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  grant_word_type         mem_reg [DEPTH];  // Storage array
  logic [PW-1:0]          wr_ptr_reg;       // Write slot
  logic [PW-1:0]          rd_ptr_reg;       // Read slot
  logic [PW:0]            count_reg;        // Occupancy
  logic                   push;             // Accepted write
  logic                   pop;              // Accepted read

  // Honest full and empty flags
  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage write; no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

endmodule // grant_buffer

// ---- rtl/grant_status_arbiter.sv ----
// Core-logic grant status arbiter with read flow control and request capture
`timescale 1ns/1ps
module grant_status_arbiter
  import gport_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Port side (inputs asynchronous to clock)
  input  wire logic                 port_clock,
  input  wire logic                 read_buffer_full_n,
  input  wire logic                 pipe_request_n,
  input  wire logic [SBA_WIDTH-1:0] sideband_address_port,
  input  wire logic                 grant_n,
  output logic [2:0]                grant_status_code,
  output logic                      grant_status_oe,
  // Configuration levels
  input  wire logic                 sideband_enable,
  input  wire logic                 core_sources_data,
  input  wire logic                 double_rate,
  // Strobe drive for the half strobes, output and enable
  output logic                      data_strobe_low_half_out,
  output logic                      data_strobe_low_half_oe,
  output logic                      data_strobe_high_half_out,
  output logic                      data_strobe_high_half_oe,
  // Core-side work scheduling
  input  wire logic                 work_valid,
  output logic                      work_ready,
  input  wire grant_word_type       work_data,
  // Captured master requests
  output logic                      request_valid,
  output request_word_type          request_data,
  // Issued grant word, for the data path
  output logic                      issued_valid,
  output grant_word_type            issued_data
);

  // Synchronisers: first stage read only by second
  logic [2:0]           clk_sync_reg;      // Port clock, extra stage for edge
  logic [1:0]           rbf_sync_reg;      // Buffer full
  logic [1:0]           pipe_sync_reg;     // Pipelined request
  logic [1:0]           gnt_sync_reg;      // Grant
  logic [SBA_WIDTH-1:0] sba_s1_reg;        // Sideband, stage one
  logic [SBA_WIDTH-1:0] sba_s2_reg;        // Sideband, stage two
  logic                 port_edge;         // Rising port clock enable
  logic                 rbf_full_reg;      // Buffer full sampled at port edge
  logic                 strobe_phase_reg;  // Strobe toggle
  logic                 strobe_park_reg;   // Parked high before release
  logic                 drive_reg;         // Strobe driving
  grant_word_type       buf_data;          // Buffer head
  logic                 buf_valid;         // Buffer not empty
  logic                 buf_take;          // Pop head this edge
  logic                 lp_blocked;        // Head is low read while full

  // Two-stage synchronisers for every port input
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // All ones: a high or a low port clock gives no false rise after reset
      clk_sync_reg  <= '1;
      rbf_sync_reg  <= 2'h3;
      pipe_sync_reg <= 2'h3;
      gnt_sync_reg  <= 2'h3;
      sba_s1_reg    <= '0;
      sba_s2_reg    <= '0;
    end else begin
      clk_sync_reg  <= {clk_sync_reg[1:0], port_clock};
      // Unconnected pin is pulled up outside, so reads deasserted
      rbf_sync_reg  <= {rbf_sync_reg[0], read_buffer_full_n};
      pipe_sync_reg <= {pipe_sync_reg[0], pipe_request_n};
      gnt_sync_reg  <= {gnt_sync_reg[0], grant_n};
      sba_s1_reg    <= sideband_address_port;
      sba_s2_reg    <= sba_s1_reg;
    end
  end

  // Issue, status, capture and strobe logic below move on port clock rising edges; the buffer accepts work on any clock
  assign port_edge = (clk_sync_reg[2:1] == EDGE_RISE);

  // Buffer-full sampled on the edge before the decision
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rbf_full_reg <= 1'b0;
    end else if (port_edge) begin
      rbf_full_reg <= ~rbf_sync_reg[1];
    end
  end

  // Buffer stalls the scheduler so no grant word is lost
  grant_buffer #(
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (work_valid),
    .in_ready  (work_ready),
    .in_data   (work_data),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_data)
  );

  // Low read held back while master buffer is full
  assign lp_blocked = (buf_data.kind == WORK_LP_READ) && rbf_full_reg;
  // Issue only on a port edge, and only if the head is not a blocked low read
  assign buf_take   = port_edge && buf_valid && !lp_blocked;

  // Status code register; reserved codes cannot be produced
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      grant_status_code <= ST_RESET;
      issued_valid      <= 1'b0;
      issued_data       <= '0;
    end else begin
      issued_valid <= buf_take;
      if (buf_take) begin
        issued_data <= buf_data;
        case (buf_data.kind)
          WORK_LP_READ:  grant_status_code <= ST_LP_READ;
          WORK_HP_READ:  grant_status_code <= ST_HP_READ;
          WORK_LP_WRITE: grant_status_code <= ST_LP_WRITE;
          WORK_HP_WRITE: grant_status_code <= ST_HP_WRITE;
          default:       grant_status_code <= ST_START_XACT;
        endcase
      end else if (port_edge && !buf_valid) begin
        // Nothing pending: let the master start a transaction
        grant_status_code <= ST_START_XACT;
      end
    end
  end

  // Status lines are a permanent output, never floated
  assign grant_status_oe = 1'b1;

  // Request capture: one per port edge while pipelined asserted
  // Sideband bytes only once configured the master keeps
  // to one mechanism so pipelined wins if both show.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      request_valid <= 1'b0;
      request_data  <= '0;
    end else begin
      request_valid <= 1'b0;
      if (port_edge) begin
        if (!pipe_sync_reg[1]) begin
          request_valid              <= 1'b1;
          request_data.from_sideband <= 1'b0;
          request_data.sideband_byte <= '0;
        end else if (sideband_enable) begin
          request_valid              <= 1'b1;
          request_data.from_sideband <= 1'b1;
          request_data.sideband_byte <= sba_s2_reg;
        end
      end
    end
  end

  // Half strobes driven while core logic sources double-rate data
  // Parked high for one port clock before release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strobe_phase_reg <= 1'b1;
      strobe_park_reg  <= 1'b0;
      drive_reg        <= 1'b0;
    end else if (port_edge) begin
      if (core_sources_data && double_rate) begin
        drive_reg        <= 1'b1;
        strobe_park_reg  <= 1'b0;
        strobe_phase_reg <= ~strobe_phase_reg;
      end else if (drive_reg && !strobe_park_reg) begin
        strobe_park_reg  <= 1'b1;
        strobe_phase_reg <= 1'b1;
      end else begin
        drive_reg        <= 1'b0;
        strobe_park_reg  <= 1'b0;
        strobe_phase_reg <= 1'b1;
      end
    end
  end

  // Same timing on both halves; gnt_sync_reg is read by no logic here
  assign data_strobe_low_half_out  = strobe_phase_reg;
  assign data_strobe_high_half_out = strobe_phase_reg;
  assign data_strobe_low_half_oe   = drive_reg;
  assign data_strobe_high_half_oe  = drive_reg;

endmodule // grant_status_arbiter

// ---- sim/gsa_checker_sva.sv ----
// Checker for the grant status arbiter ports
`timescale 1ns/1ps
module gsa_checker
  import gport_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             read_buffer_full_n,
  input wire logic             sideband_enable,
  input wire logic             core_sources_data,
  input wire logic             double_rate,
  input wire logic [2:0]       grant_status_code,
  input wire logic             grant_status_oe,
  input wire logic             data_strobe_low_half_out,
  input wire logic             data_strobe_low_half_oe,
  input wire logic             data_strobe_high_half_oe,
  input wire logic             request_valid,
  input wire request_word_type request_data,
  input wire logic             issued_valid,
  input wire grant_word_type   issued_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [6:0] full_cnt_reg; // Cycles full pin held low
  // Saturating count; 60 cycles covers a port period plus sync
  always_ff @(posedge clock or posedge rst) begin
    if (rst) full_cnt_reg <= 7'h00;
    else if (read_buffer_full_n) full_cnt_reg <= 7'h00;
    else if (full_cnt_reg != 7'h7F) full_cnt_reg <= full_cnt_reg + 7'h01;
  end
  // Low read leaves the buffer
  sequence lp_issue;
    issued_valid && issued_data.kind == WORK_LP_READ;
  endsequence
  // Strobe driven, then released in the next cycle
  sequence park_release;
    data_strobe_low_half_oe ##1 !data_strobe_low_half_oe;
  endsequence
  code_legal_a: assert property (!(grant_status_code inside {3'h4, 3'h5, 3'h6}))
    else $error("reserved status code driven");
  status_oe_a: assert property (grant_status_oe)
    else $error("status lines not driven");
  issue_code_a: assert property (issued_valid |-> grant_status_code == issued_data.kind)
    else $error("status code differs from issued kind");
  status_hold_a: assert property ($changed(grant_status_code) |->
    issued_valid || grant_status_code == ST_START_XACT)
    else $error("status changed without an issue");
  full_block_a: assert property (lp_issue |-> full_cnt_reg < 7'h3C)
    else $error("low read issued while buffer full");
  strobe_park_a: assert property (park_release |-> $past(data_strobe_low_half_out))
    else $error("strobe released without high park");
  strobe_pair_a: assert property (data_strobe_low_half_oe == data_strobe_high_half_oe)
    else $error("half strobes enabled apart");
  strobe_src_a: assert property ($rose(data_strobe_low_half_oe) |->
    $past(core_sources_data) && $past(double_rate))
    else $error("strobe driven while not sourcing");
  sideband_gate_a: assert property (request_valid && request_data.from_sideband |->
    $past(sideband_enable))
    else $error("sideband request while disabled");
  request_gap_a: assert property (request_valid |=> !request_valid [*8])
    else $error("two requests in one port cycle");
  issue_gap_a: assert property (issued_valid |=> !issued_valid [*8])
    else $error("two issues in one port cycle");
endmodule // gsa_checker
bind grant_status_arbiter gsa_checker #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.*);

// ---- sim/graphics_master_model.sv ----
// Behavioural graphics master on the port side
`timescale 1ns/1ps
module graphics_master_model
  import gport_pkg::*;
(
  input  wire logic                 mode_pipe,
  input  wire logic                 req_on,
  input  wire logic                 full_on,
  input  wire logic                 full_absent,
  input  wire logic [SBA_WIDTH-1:0] sb_byte,
  output logic                      port_clock,
  output wire logic                 read_buffer_full_n,
  output logic                      pipe_request_n,
  output logic [SBA_WIDTH-1:0]      sideband_address_port,
  output logic                      grant_n,
  output logic                      sideband_strobe
);
  logic full_reg; // Full level launched on port clock
  initial begin
    port_clock = 1'b0;
    full_reg = 1'b0;
    pipe_request_n = 1'b1;
    sideband_address_port = 8'h00;
    // Free-running port clock, 125 ns; offset keeps edges off core edges
    #1.2;
    forever #62.5 port_clock = ~port_clock;
  end
  // Only the master drives the sideband strobe, parked high in pipe mode
  assign sideband_strobe = mode_pipe ? 1'b1 : port_clock;
  // Floats when omitted; the bench net pulls it up
  assign read_buffer_full_n = full_absent ? 1'bz : !full_reg;
  // Grant held; status never read here
  assign grant_n = 1'b0;
  // One mechanism only, fixed by bench at reset; idle bytes churn
  always @(posedge port_clock) begin
    full_reg <= full_on;
    pipe_request_n <= !(mode_pipe && req_on);
    sideband_address_port <= (!mode_pipe && req_on) ? sb_byte : ~sideband_address_port;
  end
endmodule // graphics_master_model

// ---- sim/grant_status_arbiter_tb.sv ----
// Self-checking bench for the grant status arbiter
`timescale 1ns/1ps
module grant_status_arbiter_tb;
  import gport_pkg::*;
  logic             clock = 1'b0, rst = 1'b1;
  logic             port_clock, pipe_request_n, grant_n, grant_status_oe, sideband_strobe;
  tri1              read_buffer_full_n; // Pull-up on the full pin
  logic [7:0]       sideband_address_port, sb_byte = 8'hA5;
  logic [2:0]       grant_status_code;
  logic             sideband_enable = 1'b0, core_sources_data = 1'b0, double_rate = 1'b0;
  logic             data_strobe_low_half_out, data_strobe_low_half_oe;
  logic             data_strobe_high_half_out, data_strobe_high_half_oe;
  logic             work_valid = 1'b0, work_ready, request_valid, issued_valid, got;
  grant_word_type   work_data = '0, issued_data;
  request_word_type request_data;
  logic             mode_pipe = 1'b1, req_on = 1'b0, full_on = 1'b0, full_absent = 1'b0;
  int               n_errors = 0, checked = 0, cycles = 0;
  work_kind_type    kinds[5] = '{WORK_LP_READ, WORK_HP_READ, WORK_LP_WRITE,
                                 WORK_HP_WRITE, WORK_START};

  grant_status_arbiter dut_u (.*);
  graphics_master_model master_u (.*);

  // 200 MHz clock
  always #2.5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Reset held 6 cycles; master mechanism chosen meanwhile
  task automatic do_reset(input logic m);
    rst <= 1'b1;
    mode_pipe <= m;
    idle(6);
    rst <= 1'b0;
  endtask
  // Offer one work word, held until taken
  task automatic offer(input work_kind_type k);
    work_valid <= 1'b1;
    work_data <= '{kind: k, tag: 4'h3};
    while (work_ready !== 1'b1) idle(1);
    idle(1);
    work_valid <= 1'b0;
  endtask
  // Wait for a request (1) or issue (0) pulse, bounded
  task automatic wait_pulse(input logic req, output logic seen);
    seen = 1'b0;
    repeat (200) if (!seen) begin
      idle(1);
      seen = req ? request_valid === 1'b1 : issued_valid === 1'b1;
    end
  endtask
  // Every status code in turn, then idle code
  task automatic t_codes();
    foreach (kinds[i]) begin
      offer(kinds[i]);
      wait_pulse(1'b0, got);
      check(got, 8'h01);
      check(issued_data.kind, kinds[i]);
      check(grant_status_code, kinds[i]);
    end
    idle(30);
    check(grant_status_code, ST_START_XACT);
  endtask
  // Full master stalls low read; buffer fills, then drains in order
  task automatic t_full();
    full_on <= 1'b1;
    idle(60);
    offer(WORK_LP_READ);
    idle(1);
    offer(WORK_HP_READ);
    check(work_ready, 8'h00);
    wait_pulse(1'b0, got);
    check(got, 8'h00);
    full_on <= 1'b0;
    wait_pulse(1'b0, got);
    check(issued_data.kind, WORK_LP_READ);
    wait_pulse(1'b0, got);
    check(issued_data.kind, WORK_HP_READ);
  endtask
  // Omitted full pin reads as not full
  task automatic t_absent();
    full_absent <= 1'b1;
    full_on <= 1'b1;
    idle(60);
    offer(WORK_LP_READ);
    wait_pulse(1'b0, got);
    check(got, 8'h01);
    full_absent <= 1'b0;
    full_on <= 1'b0;
  endtask
  // Pipelined requests, then sideband after re-initialisation
  task automatic t_requests();
    req_on <= 1'b1;
    wait_pulse(1'b1, got);
    check(request_data.from_sideband, 8'h00);
    check(sideband_strobe, 8'h01);
    req_on <= 1'b0;
    idle(60);
    wait_pulse(1'b1, got);
    check(got, 8'h00);
    do_reset(1'b0);
    req_on <= 1'b1;
    wait_pulse(1'b1, got);
    check(got, 8'h00);
    sideband_enable <= 1'b1;
    wait_pulse(1'b1, got);
    check(request_data, {1'b1, sb_byte});
    sideband_enable <= 1'b0;
    req_on <= 1'b0;
  endtask
  // Strobes driven while sourcing double-rate data, then parked high and released
  task automatic t_strobe();
    core_sources_data <= 1'b1;
    double_rate <= 1'b1;
    idle(60);
    check(data_strobe_low_half_oe, 8'h01);
    check(data_strobe_high_half_oe, 8'h01);
    core_sources_data <= 1'b0;
    idle(90);
    check(data_strobe_low_half_oe, 8'h00);
    check(data_strobe_high_half_out, 8'h01);
    double_rate <= 1'b0;
  endtask
  initial begin
    do_reset(1'b1);
    t_codes();
    t_full();
    t_absent();
    t_requests();
    t_strobe();
    conclude();
  end
endmodule // grant_status_arbiter_tb
